// ### crossing_event_unit.sv
// Purpose: logic output and crossing event generation
// Assumes: sink_sync already synchronised to clk_sys
// Notes: event_p is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module crossing_event_unit (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  crossing_evt_if.unit ev
);
  import zero_cross_pkg::*;
  logic level_nxt;
  logic level_r;
  logic invert_r;
  logic rise_p;
  logic fall_p;
  logic pol_p;

  // inactive detector reads low before inversion
  assign level_nxt = (ev.active & ev.sink_sync) ^ ev.invert;
  assign ev.level = level_r;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      level_r <= 1'b0;
    end else if (clk_en) begin
      level_r <= level_nxt;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      invert_r <= RST_POL;
    end else if (clk_en) begin
      invert_r <= ev.invert;
    end
  end

  // edges seen on the inverted value, so a polarity flip is an edge too
  assign rise_p = ~level_r & level_nxt & ev.rise_en;
  assign fall_p = level_r & ~level_nxt & ev.fall_en;
  assign pol_p = invert_r ^ ev.invert;
  assign ev.event_p = clk_en & (rise_p | fall_p | pol_p);
endmodule
`default_nettype wire

// ### crossing_evt_if.sv
// Purpose: carries detector level and edge settings to the event unit
// Assumes: all signals on clk_sys
// Notes: none
`timescale 1ns/1ps
`default_nettype none
interface crossing_evt_if;
  logic active;
  logic sink_sync;
  logic invert;
  logic rise_en;
  logic fall_en;
  logic level;
  logic event_p;
  modport ctrl (output active, output sink_sync, output invert, output rise_en,
    output fall_en, input level, input event_p);
  modport unit (input active, input sink_sync, input invert, input rise_en,
    input fall_en, output level, output event_p);
endinterface
`default_nettype wire

// ### tb_zero_cross_ctrl.sv
// Purpose: self-checking bench for zero_cross_ctrl
// Assumes: strap changes only while reset is held
// Notes: rows walk edge and polarity cases in order
`timescale 1ns/1ps
`default_nettype none
module tb_zero_cross_ctrl;
  import zero_cross_pkg::*;
  logic clk_sys, sys_rst, clk_en, psel, penable, pwrite, pready, pslverr, e;
  logic detector_default_off, sink_active, detector_active, detector_level, crossing_irq;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int err_total, samples_checked;
  // ctrl byte, sink, level, flag; rows depend on the row before
  logic [10:0] rows [8] = '{11'h017, 11'h010, 11'h00E, 11'h009,
    11'h08A, 11'h08D, 11'h094, 11'h093};
  zero_cross_ctrl DUT (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .detector_default_off(detector_default_off),
    .sink_active(sink_active),
    .detector_active(detector_active),
    .detector_level(detector_level),
    .crossing_irq(crossing_irq)
  );
  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    samples_checked++;
    if (g !== x) begin
      err_total++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, x, g);
    end
  endtask
  // no wait limit here: only the watchdog ends a stalled transfer
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
    @(posedge clk_sys);
    penable <= 1'h1;
    do @(posedge clk_sys); while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task automatic rst(input logic s);
    sys_rst <= 1'h1;
    detector_default_off <= s;
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'h0;
    repeat (6) @(posedge clk_sys);
  endtask
  task automatic give_verdict;
    if (err_total == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    give_verdict();
  end
  initial begin
    sys_rst = 1'h1;
    clk_en = 1'h1;
    {psel, penable, pwrite, paddr, pwdata, detector_default_off, sink_active} = '0;
    rst(1'h1);
    chk("active", 0, detector_active);
    bus(1'h1, OFS_CTRL, 32'h80);
    repeat (4) @(posedge clk_sys);
    chk("active", 1, detector_active);
    bus(1'h1, OFS_GATE, 32'h1);
    repeat (4) @(posedge clk_sys);
    chk("active", 0, detector_active);
    rst(1'h0);
    bus(1'h1, OFS_GATE, 32'h1);
    repeat (4) @(posedge clk_sys);
    chk("active", 1, detector_active);
    bus(1'h1, OFS_CTRL, 32'hFFFFFFFF);
    bus(1'h0, OFS_CTRL, 32'h0);
    chk("ctrl", 32'hB3, q);
    bus(1'h1, OFS_MASK, 32'h1);
    bus(1'h1, OFS_CTRL, 32'h0);
    foreach (rows[i]) begin
      bus(1'h1, OFS_CTRL, {24'h0, rows[i][10:3]});
      bus(1'h1, OFS_STAT, 32'h1);
      sink_active <= rows[i][2];
      repeat (6) @(posedge clk_sys);
      chk("level", rows[i][1], detector_level);
      chk("irq", rows[i][0], crossing_irq);
      bus(1'h0, OFS_STAT, 32'h0);
      chk("flag", rows[i][0], q);
    end
    bus(1'h0, 4'h1, 32'h0);
    chk("slverr", 1, e);
    bus(1'h1, OFS_STAT, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk("irq", 0, crossing_irq);
    bus(1'h1, OFS_CTRL, 32'h0);
    repeat (3) @(posedge clk_sys);
    chk("irq", 1, crossing_irq);
    bus(1'h1, OFS_MASK, 32'h0);
    repeat (2) @(posedge clk_sys);
    chk("irq", 0, crossing_irq);
    bus(1'h0, OFS_STAT, 32'h0);
    chk("flag", 1, q);
    clk_en <= 1'h0;
    sink_active <= 1'h1;
    repeat (6) @(posedge clk_sys);
    chk("pready", 0, pready);
    chk("level", 0, detector_level);
    clk_en <= 1'h1;
    repeat (6) @(posedge clk_sys);
    chk("level", 1, detector_level);
    give_verdict();
  end
endmodule
`default_nettype wire

// ### zero_cross_ctrl.sv
// Purpose: zero-crossing detector control with apb registers and interrupt
// Assumes: sink_active and detector_default_off arrive asynchronously
// Notes: zero wait-state apb slave while clk_en is high
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module zero_cross_ctrl (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [zero_cross_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic detector_default_off,
  input wire logic sink_active,
  output logic detector_active,
  output logic detector_level,
  output logic crossing_irq
);
  import zero_cross_pkg::*;

  crossing_evt_if ev ();

  // one flop would let a metastable strap or comparator level reach the logic
  if (SYNC_STAGES < 2) begin : g_sync_check
    $error("SYNC_STAGES must be at least 2");
  end
  if (CTRL_W <= BIT_EN) begin : g_ctrl_check
    $error("CTRL_W is too narrow for the control bits");
  end

  logic [SYNC_STAGES-1:0] cfg_sync_r;
  logic [SYNC_STAGES-1:0] sink_sync_r;
  logic [SYNC_STAGES-1:0] cfg_fill_r;
  logic cfg_taken_r;
  logic default_off_r;
  logic en_r;
  logic pol_r;
  logic rise_r;
  logic fall_r;
  logic flag_r;
  logic mask_r;
  logic gate_r;
  logic active_r;
  logic active_nxt;
  logic [31:0] prdata_r;
  logic [31:0] rd_nxt;
  logic mapped;
  logic wr_take;
  logic rd_setup;
  logic [CTRL_W-1:0] ctrl_view;

  // the strap and the comparator level both cross into clk_sys here
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_sync_r <= '0;
      sink_sync_r <= '0;
    end else if (clk_en) begin
      cfg_sync_r <= {cfg_sync_r[SYNC_STAGES-2:0], detector_default_off};
      sink_sync_r <= {sink_sync_r[SYNC_STAGES-2:0], sink_active};
    end
  end

  // the strap synchroniser is held clear in reset, so its output is only
  // worth capturing once a strap value has walked through every stage
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_fill_r <= '0;
    end else if (clk_en) begin
      cfg_fill_r <= {cfg_fill_r[SYNC_STAGES-2:0], 1'b1};
    end
  end

  // strap caught once after release; later changes are ignored like a fuse
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_taken_r <= 1'b0;
      default_off_r <= 1'b1;
    end else if (clk_en && !cfg_taken_r && cfg_fill_r[SYNC_STAGES-1]) begin
      cfg_taken_r <= 1'b1;
      default_off_r <= cfg_sync_r[SYNC_STAGES-1];
    end
  end

  assign wr_take = psel & penable & pwrite & clk_en;
  assign rd_setup = psel & ~penable & ~pwrite & clk_en;
  assign mapped = (paddr == OFS_CTRL) | (paddr == OFS_STAT) |
                  (paddr == OFS_MASK) | (paddr == OFS_GATE);
  // pready follows clk_en, so a frozen block simply stalls the bus
  assign pready = clk_en;
  assign pslverr = psel & penable & clk_en & ~mapped;

  // enable bit resets clear, so the detector starts off when default-off is set
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      en_r <= RST_EN;
      pol_r <= RST_POL;
      rise_r <= RST_RISE;
      fall_r <= RST_FALL;
    end else if (wr_take && paddr == OFS_CTRL) begin
      en_r <= pwdata[BIT_EN];
      pol_r <= pwdata[BIT_POL];
      rise_r <= pwdata[BIT_RISE];
      fall_r <= pwdata[BIT_FALL];
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mask_r <= RST_MASK;
    end else if (wr_take && paddr == OFS_MASK) begin
      mask_r <= pwdata[BIT_FLAG];
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      gate_r <= RST_GATE;
    end else if (wr_take && paddr == OFS_GATE) begin
      gate_r <= pwdata[BIT_GATE];
    end
  end

  // gate only bites when the strap lets software own the detector
  always_comb begin
    if (default_off_r) begin
      active_nxt = en_r & ~gate_r;
    end else begin
      active_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      active_r <= 1'b0;
    end else if (clk_en) begin
      active_r <= active_nxt & cfg_taken_r;
    end
  end

  assign ev.active = active_r;
  assign ev.sink_sync = sink_sync_r[SYNC_STAGES-1];
  assign ev.invert = pol_r;
  assign ev.rise_en = rise_r;
  assign ev.fall_en = fall_r;

  crossing_event_unit u_event (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .ev(ev)
  );

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      flag_r <= 1'b0;
    end else if (ev.event_p) begin
      flag_r <= 1'b1;
    end else if (wr_take && paddr == OFS_STAT && pwdata[BIT_FLAG]) begin
      flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      crossing_irq <= 1'b0;
    end else if (clk_en) begin
      crossing_irq <= flag_r & mask_r;
    end
  end

  always_comb begin
    ctrl_view = '0;
    ctrl_view[BIT_EN] = en_r;
    ctrl_view[BIT_OUT] = ev.level;
    ctrl_view[BIT_POL] = pol_r;
    ctrl_view[BIT_RISE] = rise_r;
    ctrl_view[BIT_FALL] = fall_r;
  end

  always_comb begin
    rd_nxt = '0;
    unique case (paddr)
      OFS_CTRL: rd_nxt[CTRL_W-1:0] = ctrl_view;
      OFS_STAT: rd_nxt[BIT_FLAG] = flag_r;
      OFS_MASK: rd_nxt[BIT_FLAG] = mask_r;
      OFS_GATE: rd_nxt[BIT_GATE] = gate_r;
      default: rd_nxt = '0;
    endcase
  end

  // read data sampled in the setup cycle so it comes from a flop
  // limitation: clk_en must be high at the setup edge of a read
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      prdata_r <= '0;
    end else if (rd_setup) begin
      prdata_r <= rd_nxt;
    end
  end

  assign prdata = prdata_r;
  assign detector_active = active_r;
  assign detector_level = ev.level;
endmodule
`default_nettype wire

// ### zero_cross_ctrl_chk.sv
// Purpose: port checks for zero_cross_ctrl
// Assumes: one clk_sys domain, strap moves only in reset
// Notes: shadows of written bits stand in for hidden state
`timescale 1ns/1ps
`default_nettype none
module zero_cross_ctrl_chk (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [zero_cross_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic detector_default_off,
  input wire logic sink_active,
  input wire logic detector_active,
  input wire logic detector_level,
  input wire logic crossing_irq
);
  import zero_cross_pkg::*;
  logic wr;
  logic en_r, pol_r, rise_r, fall_r, mask_r;
  assign wr = psel && penable && pwrite && clk_en;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      {en_r, pol_r, rise_r, fall_r} <= 4'h0;
    end else if (wr && paddr == OFS_CTRL) begin
      {en_r, pol_r, rise_r, fall_r} <= {pwdata[BIT_EN], pwdata[BIT_POL], pwdata[1:0]};
    end
  end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mask_r <= 1'h0;
    end else if (wr && paddr == OFS_MASK) begin
      mask_r <= pwdata[0];
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_off_default: assert property (
    (detector_default_off && !en_r)[*4] |=> !detector_active) else $error("active while off");
  a_on_always: assert property (
    (!detector_default_off)[*4] |=> detector_active) else $error("inactive with strap clear");
  a_ctrl_zeros: assert property (
    psel && penable && !pwrite && paddr == OFS_CTRL |-> prdata[31:8] == 24'h0
    && prdata[6] == 1'h0 && prdata[3:2] == 2'h0) else $error("unimplemented bit set");
  a_level_map: assert property (
    (detector_active && clk_en && $stable(sink_active) && $stable(pol_r))[*5]
    |-> detector_level == (sink_active ^ pol_r)) else $error("level wrong");
  a_rise_flag: assert property (
    $rose(detector_level) && rise_r && mask_r |-> ##[0:2] crossing_irq) else $error("no rise irq");
  a_fall_flag: assert property (
    $fell(detector_level) && fall_r && mask_r |-> ##[0:2] crossing_irq) else $error("no fall irq");
  a_pol_irq: assert property (
    wr && paddr == OFS_CTRL && pwdata[BIT_POL] != pol_r && mask_r |-> ##[1:3] crossing_irq)
    else $error("no polarity irq");
  a_irq_masked: assert property (
    crossing_irq |-> $past(mask_r)) else $error("irq while masked");
endmodule
bind zero_cross_ctrl zero_cross_ctrl_chk chk (
  .clk_sys(clk_sys),
  .sys_rst(sys_rst),
  .clk_en(clk_en),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .detector_default_off(detector_default_off),
  .sink_active(sink_active),
  .detector_active(detector_active),
  .detector_level(detector_level),
  .crossing_irq(crossing_irq)
);
`default_nettype wire

// ### zero_cross_pkg.sv
// Purpose: shared constants for the zero-crossing detector control block
// Assumes: 32-bit apb data, one aligned word per register
// Notes: control layout keeps the 8-bit field positions in the low byte
package zero_cross_pkg;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_STAT = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_MASK = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_GATE = 4'hC;
  localparam int CTRL_W = 8;
  localparam int BIT_EN = 7;
  localparam int BIT_OUT = 5;
  localparam int BIT_POL = 4;
  localparam int BIT_RISE = 1;
  localparam int BIT_FALL = 0;
  localparam int BIT_FLAG = 0;
  localparam int BIT_GATE = 0;
  localparam logic RST_EN = 1'b0;
  localparam logic RST_POL = 1'b0;
  localparam logic RST_RISE = 1'b0;
  localparam logic RST_FALL = 1'b0;
  localparam logic RST_MASK = 1'b0;
  localparam logic RST_GATE = 1'b0;
  localparam int SYNC_STAGES = 2;
endpackage
